// [psrw_top.sv]
// Power management, sleep and wake, reset cause and watchdog logic.
// Assumes a synchronous SFR port and raw asynchronous wake and supply pins.
`timescale 1ns/1ps
module psrw_top #(
	parameter int HOT_DELAY_CYCLES = psrw_pkg::HOT_DELAY_US * (psrw_pkg::CLK_HZ / 1000000),
	parameter int POR_DELAY_CYCLES = psrw_pkg::POR_DELAY_US * (psrw_pkg::CLK_HZ / 1000000),
	parameter int WDOG_DIV_CYCLES  = psrw_pkg::WDOG_DIVIDE
) (
	input  wire logic       sys_clk_in,
	input  wire logic       nrst_in,
	input  wire logic       sfr_wr_in,
	input  wire logic [7:0] sfr_addr_in,
	input  wire logic [7:0] sfr_wdata_in,
	output logic      [7:0] sfr_rdata_out,
	input  wire logic       supply_low_in,
	input  wire logic       reset_pin_in,
	input  wire logic       external_reset_pin_enable_in,
	input  wire logic       wdog_irq_enter_in,
	input  wire logic       usb_event_in,
	input  wire logic       uart1_rs485_in,
	input  wire logic       uart1_pin_mode_in,
	input  wire logic       uart1_rx_in,
	input  wire logic       uart1_rx_alt_in,
	input  wire logic       uart1_diff_rx_in,
	input  wire logic       uart0_rx_in,
	input  wire logic       pin15_in,
	input  wire logic       pin14_in,
	input  wire logic       pin03_in,
	input  wire logic       timer3_capture_in,
	input  wire logic       pin33_in,
	output logic            cpu_reset_out,
	output logic            sleeping_out,
	output logic      [7:0] module_clock_off_out,
	output logic            uart0_double_baud_out
);
	// ****************************************
	// Input synchronisers
	// ****************************************
	localparam int NSYNC = 10;
	logic [NSYNC-1:0] raw_w;
	logic [NSYNC-1:0] s1_r;
	logic [NSYNC-1:0] s2_r;
	logic [NSYNC-1:0] s3_r;
	logic [NSYNC-1:0] clean_r;
	logic             uart1_src_w;

	always_comb begin
		uart1_src_w = uart1_rs485_in ? uart1_diff_rx_in
			: (uart1_pin_mode_in ? uart1_rx_alt_in : uart1_rx_in);
	end
	assign raw_w = {supply_low_in, reset_pin_in, usb_event_in, uart1_src_w, pin15_in,
		pin14_in, pin03_in, timer3_capture_in, pin33_in, uart0_rx_in};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge sys_clk_in or negedge nrst_in) begin
				// Each stage resets to its pin's idle level, so no false wake edge follows reset.
				if (!nrst_in) begin
					s1_r[gi]    <= psrw_pkg::SYNC_IDLE[gi];
					s2_r[gi]    <= psrw_pkg::SYNC_IDLE[gi];
					s3_r[gi]    <= psrw_pkg::SYNC_IDLE[gi];
					clean_r[gi] <= psrw_pkg::SYNC_IDLE[gi];
				end else begin
					s1_r[gi] <= raw_w[gi];
					s2_r[gi] <= s1_r[gi];
					s3_r[gi] <= s2_r[gi];
					if (s2_r[gi] == s3_r[gi]) begin
						clean_r[gi] <= s3_r[gi];
					end
				end
			end
		end
	endgenerate

	logic        supply_low_w;
	logic        pin_high_w;
	logic [7:0]  wake_level_w;
	logic        p33_edge_w;
	logic        p33_prev_r;
	assign supply_low_w = clean_r[9];
	assign pin_high_w   = clean_r[8];

	// ****************************************
	// Registers and state
	// ****************************************
	logic [7:0]  gate_r;
	logic [7:0]  wake_r;
	logic [7:0]  keep_r;
	logic [7:0]  wcnt_r;
	logic [7:0]  rdata_r;
	logic [1:0]  cause_r;
	logic        sleep_r;
	logic        double_baud_r;
	logic        gen_flag_one_r;
	logic        gen_flag_zero_r;
	logic        loader_r;
	logic        wdog_en_r;
	logic        swrst_r;
	logic        wflag_r;
	logic        unlock_armed_r;
	logic        cpu_reset_r;
	logic [4:0]  window_r;
	logic [17:0] wdiv_r;
	logic [18:0] hold_r;
	logic [15:0] pin_cnt_r;
	logic        pin_fired_r;

	logic        wr_w;
	logic        open_w;
	logic        wdog_tick_w;
	logic        wdog_ovf_w;
	logic        sw_req_w;
	logic        wd_req_w;
	logic        hot_w;
	logic        wake_w;

	function automatic logic hit(input logic [7:0] a);
		hit = wr_w && (sfr_addr_in == a);
	endfunction

	assign wr_w         = sfr_wr_in && !cpu_reset_r;
	assign open_w       = window_r != 5'h00;
	assign wdog_tick_w  = wdiv_r == 18'(WDOG_DIV_CYCLES - 1);
	assign wdog_ovf_w   = wdog_tick_w && (wcnt_r == 8'hff) && !hit(psrw_pkg::ADDR_WDOG_COUNTER);
	assign sw_req_w     = swrst_r;
	assign wd_req_w     = wdog_ovf_w && wdog_en_r;
	assign hot_w        = sw_req_w || wd_req_w || pin_fired_r;
	assign wake_level_w = {clean_r[7], ~clean_r[6:0]};
	assign p33_edge_w   = clean_r[1] != p33_prev_r;
	assign wake_w       = sleep_r && ((|(wake_r & wake_level_w)) || (wake_r[1] && p33_edge_w));

	// ****************************************
	// Reset sequencing
	// ****************************************
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			hold_r      <= 19'(POR_DELAY_CYCLES);
			cpu_reset_r <= 1'b1;
		end else if (supply_low_w) begin
			hold_r      <= 19'(POR_DELAY_CYCLES);
			cpu_reset_r <= 1'b1;
		end else if (hot_w) begin
			hold_r      <= 19'(HOT_DELAY_CYCLES);
			cpu_reset_r <= 1'b1;
		end else if (hold_r != 19'h00000) begin
			hold_r      <= hold_r - 19'h00001;
			cpu_reset_r <= 1'b1;
		end else begin
			cpu_reset_r <= 1'b0;
		end
	end
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pin_cnt_r   <= 16'h0000;
			pin_fired_r <= 1'b0;
		end else if (!(pin_high_w && external_reset_pin_enable_in)) begin
			pin_cnt_r   <= 16'h0000;
			pin_fired_r <= 1'b0;
		end else if (pin_cnt_r == 16'(psrw_pkg::PIN_MIN_CYCLES)) begin
			pin_fired_r <= 1'b1;
		end else begin
			pin_cnt_r <= pin_cnt_r + 16'h0001;
		end
	end
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cause_r  <= psrw_pkg::CAUSE_POWER_ON;
			loader_r <= 1'b1;
		end else if (supply_low_w) begin
			cause_r  <= psrw_pkg::CAUSE_POWER_ON;
			loader_r <= 1'b1;
		end else if (pin_fired_r) begin
			cause_r <= psrw_pkg::CAUSE_PIN;
		end else if (wd_req_w) begin
			cause_r <= psrw_pkg::CAUSE_WATCHDOG;
		end else if (sw_req_w) begin
			if (!loader_r || wdog_en_r) begin
				cause_r <= psrw_pkg::CAUSE_SOFTWARE;
			end
			loader_r <= 1'b0;
		end
	end
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			keep_r <= psrw_pkg::RST_ZERO;
		end else if (supply_low_w) begin
			keep_r <= psrw_pkg::RST_ZERO;
		end else if (hit(psrw_pkg::ADDR_SCRATCH)) begin
			keep_r <= sfr_wdata_in;
		end
	end

	// ****************************************
	// Register writes
	// ****************************************
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			unlock_armed_r <= 1'b0;
			window_r       <= 5'h00;
		end else if (cpu_reset_r) begin
			unlock_armed_r <= 1'b0;
			window_r       <= 5'h00;
		end else if (hit(psrw_pkg::ADDR_UNLOCK)) begin
			unlock_armed_r <= sfr_wdata_in == psrw_pkg::UNLOCK_FIRST;
			if (unlock_armed_r && sfr_wdata_in == psrw_pkg::UNLOCK_SECOND) begin
				window_r <= 5'(psrw_pkg::WINDOW_CLOCKS);
			end else begin
				window_r <= 5'h00;
			end
		end else if (open_w) begin
			window_r <= window_r - 5'h01;
		end
	end
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			double_baud_r   <= 1'b0;
			gen_flag_one_r  <= 1'b0;
			gen_flag_zero_r <= 1'b0;
			sleep_r         <= 1'b0;
		end else if (cpu_reset_r) begin
			double_baud_r   <= 1'b0;
			gen_flag_one_r  <= 1'b0;
			gen_flag_zero_r <= 1'b0;
			sleep_r         <= 1'b0;
		end else if (hit(psrw_pkg::ADDR_POWER_CONTROL)) begin
			double_baud_r   <= sfr_wdata_in[psrw_pkg::POS_UART0_DOUBLE];
			gen_flag_one_r  <= sfr_wdata_in[psrw_pkg::POS_GEN_FLAG_ONE];
			gen_flag_zero_r <= sfr_wdata_in[psrw_pkg::POS_GEN_FLAG_ZERO];
			sleep_r         <= sfr_wdata_in[psrw_pkg::POS_SLEEP_REQUEST];
		end else if (wake_w) begin
			sleep_r <= 1'b0;
		end
	end
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			gate_r <= psrw_pkg::RST_ZERO;
			wake_r <= psrw_pkg::RST_ZERO;
		end else if (cpu_reset_r) begin
			gate_r <= psrw_pkg::RST_ZERO;
			wake_r <= psrw_pkg::RST_ZERO;
		end else if (open_w) begin
			if (hit(psrw_pkg::ADDR_CLOCK_GATE)) begin
				gate_r <= sfr_wdata_in;
			end
			if (hit(psrw_pkg::ADDR_WAKE_ENABLE)) begin
				wake_r <= sfr_wdata_in;
			end
		end
	end
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wdog_en_r <= 1'b0;
			swrst_r   <= 1'b0;
		end else if (cpu_reset_r) begin
			wdog_en_r <= 1'b0;
			swrst_r   <= 1'b0;
		end else if (swrst_r) begin
			swrst_r <= 1'b0;
		end else if (open_w && hit(psrw_pkg::ADDR_GLOBAL_CFG)) begin
			wdog_en_r <= sfr_wdata_in[psrw_pkg::POS_WDOG_RESET_EN];
			swrst_r   <= sfr_wdata_in[psrw_pkg::POS_SOFT_RESET];
		end
	end

	// ****************************************
	// Watchdog
	// ****************************************
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wdiv_r  <= 18'h00000;
			wcnt_r  <= psrw_pkg::RST_ZERO;
			wflag_r <= 1'b0;
		end else if (cpu_reset_r) begin
			wdiv_r  <= 18'h00000;
			wcnt_r  <= psrw_pkg::RST_ZERO;
			wflag_r <= 1'b0;
		end else begin
			wdiv_r <= wdog_tick_w ? 18'h00000 : wdiv_r + 18'h00001;
			if (hit(psrw_pkg::ADDR_WDOG_COUNTER)) begin
				wcnt_r <= sfr_wdata_in;
			end else if (wdog_tick_w) begin
				wcnt_r <= wcnt_r + 8'h01;
			end
			// An overflow beats an interrupt-entry clear in the same cycle; a counter write in that cycle suppresses the overflow.
			if (wdog_ovf_w) begin
				wflag_r <= 1'b1;
			end else if (hit(psrw_pkg::ADDR_WDOG_COUNTER) || wdog_irq_enter_in) begin
				wflag_r <= 1'b0;
			end
		end
	end
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			p33_prev_r <= psrw_pkg::SYNC_IDLE[1];
		end else begin
			p33_prev_r <= clean_r[1];
		end
	end
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_r <= psrw_pkg::RST_ZERO;
		end else begin
			case (sfr_addr_in)
				psrw_pkg::ADDR_POWER_CONTROL: rdata_r <= {double_baud_r, 1'b0, cause_r, gen_flag_one_r,
					gen_flag_zero_r, sleep_r, 1'b0};
				psrw_pkg::ADDR_CLOCK_GATE:    rdata_r <= gate_r;
				psrw_pkg::ADDR_WAKE_ENABLE:   rdata_r <= wake_r;
				psrw_pkg::ADDR_SCRATCH:       rdata_r <= keep_r;
				psrw_pkg::ADDR_WDOG_COUNTER:  rdata_r <= wcnt_r;
				psrw_pkg::ADDR_GLOBAL_CFG:    rdata_r <= {psrw_pkg::GCFG_FIXED_HI, loader_r, swrst_r, 3'h0, wdog_en_r};
				psrw_pkg::ADDR_CLOCK_CFG:     rdata_r <= {2'h0, wflag_r, 5'h00};
				default:                      rdata_r <= psrw_pkg::RST_ZERO;
			endcase
		end
	end
	assign sfr_rdata_out         = rdata_r;
	assign cpu_reset_out         = cpu_reset_r;
	assign sleeping_out          = sleep_r;
	assign module_clock_off_out  = gate_r;
	assign uart0_double_baud_out = double_baud_r;
endmodule // psrw_top

// [psrw_pkg.sv]
// Package: constants for the power, sleep, reset and watchdog block.
// Assumes an 8-bit special-function register port from the processor core.
package psrw_pkg;
	// ****************************************
	// Register addresses
	// ****************************************
	localparam logic [7:0] ADDR_POWER_CONTROL  = 8'h87;
	localparam logic [7:0] ADDR_CLOCK_GATE     = 8'hea;
	localparam logic [7:0] ADDR_WAKE_ENABLE    = 8'heb;
	localparam logic [7:0] ADDR_SCRATCH        = 8'hfe;
	localparam logic [7:0] ADDR_WDOG_COUNTER   = 8'hff;
	localparam logic [7:0] ADDR_UNLOCK         = 8'ha1;
	localparam logic [7:0] ADDR_GLOBAL_CFG     = 8'hb1;
	localparam logic [7:0] ADDR_CLOCK_CFG      = 8'hb3;
	// ****************************************
	// Reset values and field positions
	// ****************************************
	localparam logic [7:0] RST_POWER_CONTROL   = 8'h10;
	localparam logic [7:0] RST_ZERO            = 8'h00;
	localparam logic [9:0] SYNC_IDLE           = 10'h07f;
	localparam int         POS_UART0_DOUBLE    = 7;
	localparam int         POS_CAUSE_HI        = 5;
	localparam int         POS_CAUSE_LO        = 4;
	localparam int         POS_GEN_FLAG_ONE    = 3;
	localparam int         POS_GEN_FLAG_ZERO   = 2;
	localparam int         POS_SLEEP_REQUEST   = 1;
	localparam int         POS_LOADER_STATE    = 5;
	localparam int         POS_SOFT_RESET      = 4;
	localparam int         POS_WDOG_RESET_EN   = 0;
	localparam int         POS_WDOG_FLAG       = 5;
	localparam logic [1:0] GCFG_FIXED_HI       = 2'h3;
	localparam logic [7:0] UNLOCK_FIRST        = 8'h55;
	localparam logic [7:0] UNLOCK_SECOND       = 8'haa;
	// ****************************************
	// Reset causes and timing
	// ****************************************
	localparam logic [1:0] CAUSE_SOFTWARE      = 2'h0;
	localparam logic [1:0] CAUSE_POWER_ON      = 2'h1;
	localparam logic [1:0] CAUSE_WATCHDOG      = 2'h2;
	localparam logic [1:0] CAUSE_PIN           = 2'h3;
	localparam int         CLK_HZ              = 20000000;
	localparam int         WINDOW_CLOCKS       = 18;
	localparam int         WDOG_DIVIDE         = 262144;
	localparam int         PIN_MIN_PULSE_NS    = 1000;
	localparam int         PIN_MIN_CYCLES      = (PIN_MIN_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int         HOT_DELAY_US        = 100;
	localparam int         POR_DELAY_US        = 10000;
	typedef enum logic [1:0] {ST_RUN, ST_HOLD} psrw_state_type;
endpackage

// [psrw_chk.sv]
// Checker for the power, sleep, reset and watchdog block.
// Sees only the ports of psrw_top and is attached by bind.
`timescale 1ns/1ps
module psrw_chk (
	input wire logic       sys_clk_in,
	input wire logic       nrst_in,
	input wire logic       sfr_wr_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic       supply_low_in,
	input wire logic       cpu_reset_out,
	input wire logic       sleeping_out,
	input wire logic [7:0] module_clock_off_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);
	wire logic pc_wr = sfr_wr_in && sfr_addr_in == psrw_pkg::ADDR_POWER_CONTROL;
	wire logic cg_wr = sfr_wr_in && sfr_addr_in == psrw_pkg::ADDR_CLOCK_GATE;
	sequence supply_back;
		$fell(supply_low_in);
	endsequence
	sequence supply_gone;
		supply_low_in [*8];
	endsequence
	supply_hold_a: assert property (supply_low_in [*5] |=> cpu_reset_out)
		else $error("no reset on low supply");
	por_delay_a: assert property (supply_back |-> cpu_reset_out[*8])
		else $error("reset released early");
	run_supply_a: assert property ($fell(cpu_reset_out) |-> !supply_low_in)
		else $error("running on low supply");
	sleep_enter_a: assert property (pc_wr && sfr_wdata_in[1] && !cpu_reset_out |=> sleeping_out)
		else $error("no sleep after request");
	awake_stay_a: assert property (!sleeping_out && !pc_wr |=> !sleeping_out)
		else $error("sleep without request");
	gate_hold_a: assert property (!cpu_reset_out && !cg_wr |=> $stable(module_clock_off_out))
		else $error("clock gate changed");
	gate_por_a: assert property (supply_gone |-> module_clock_off_out == 8'h00)
		else $error("clock gate not cleared");
	reset_sleep_a: assert property (supply_gone |-> !sleeping_out)
		else $error("asleep in reset");
endmodule // psrw_chk
bind psrw_top psrw_chk psrw_chk_inst (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .sfr_wr_in(sfr_wr_in),
	.sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in), .supply_low_in(supply_low_in),
	.cpu_reset_out(cpu_reset_out), .sleeping_out(sleeping_out), .module_clock_off_out(module_clock_off_out));

// [psrw_top_test.sv]
// Testbench for the power, sleep, reset and watchdog block.
// Drives the reset, SFR, supply, reset-pin and USB inputs at the falling clock edge; the other inputs are tied to constant levels.
`timescale 1ns/1ps
module psrw_top_test;
	logic       clk = 0, nrst = 0, wr = 0, sup = 0, rpin = 0, pen = 0, usb = 0, m = 0, h = 1, rst, slp;
	logic [7:0] a = 0, d = 0, q, off;
	int         miscompares = 0, num_checks = 0;
	always #25 clk = ~clk;
	psrw_top #(.HOT_DELAY_CYCLES(10), .POR_DELAY_CYCLES(12), .WDOG_DIV_CYCLES(4)) psrw_top_inst (
		.sys_clk_in(clk), .nrst_in(nrst), .sfr_wr_in(wr), .sfr_addr_in(a), .sfr_wdata_in(d), .sfr_rdata_out(q),
		.supply_low_in(sup), .reset_pin_in(rpin), .external_reset_pin_enable_in(pen), .wdog_irq_enter_in(m),
		.usb_event_in(usb), .uart1_rs485_in(m), .uart1_pin_mode_in(m), .uart1_rx_in(h), .uart1_rx_alt_in(h),
		.uart1_diff_rx_in(h), .uart0_rx_in(h), .pin15_in(h), .pin14_in(h), .pin03_in(h), .timer3_capture_in(h),
		.pin33_in(h), .cpu_reset_out(rst), .sleeping_out(slp), .module_clock_off_out(off), .uart0_double_baud_out());
	task automatic cmp(input logic [7:0] g, e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic wt(input logic [7:0] ad, v);
		@(negedge clk) {wr, a, d} = {1'b1, ad, v};
		@(negedge clk) wr = 0;
	endtask
	task automatic chk(input logic [7:0] ad, e);
		@(negedge clk) a = ad;
		@(negedge clk) cmp(q, e);
	endtask
	task automatic unlock;
		wt(psrw_pkg::ADDR_UNLOCK, psrw_pkg::UNLOCK_FIRST);
		wt(psrw_pkg::ADDR_UNLOCK, psrw_pkg::UNLOCK_SECOND);
	endtask
	task automatic wait_rst(input logic lvl);
		for (int i = 0; i < 300 && rst !== lvl; i++) @(negedge clk);
		cmp({7'h00, rst}, {7'h00, lvl});
	endtask
	task automatic t_protect;
		wt(psrw_pkg::ADDR_WAKE_ENABLE, 8'hff);
		chk(psrw_pkg::ADDR_WAKE_ENABLE, 8'h00);
		unlock();
		wt(psrw_pkg::ADDR_WAKE_ENABLE, 8'h80);
		chk(psrw_pkg::ADDR_WAKE_ENABLE, 8'h80);
		$display("protect done");
	endtask
	task automatic t_sleep;
		wt(psrw_pkg::ADDR_POWER_CONTROL, 8'h02);
		cmp({7'h00, slp}, 8'h01);
		@(negedge clk) usb = 1;
		repeat (3) @(negedge clk);
		usb = 0;
		repeat (3) @(negedge clk);
		chk(psrw_pkg::ADDR_POWER_CONTROL, 8'h10);
		$display("sleep done");
	endtask
	task automatic t_wdog;
		wt(psrw_pkg::ADDR_SCRATCH, 8'h5a);
		unlock();
		wt(psrw_pkg::ADDR_GLOBAL_CFG, 8'h01);
		wt(psrw_pkg::ADDR_WDOG_COUNTER, 8'h00);
		cmp({7'h00, rst}, 8'h00);
		wt(psrw_pkg::ADDR_WDOG_COUNTER, 8'hff);
		wait_rst(1);
		wait_rst(0);
		chk(psrw_pkg::ADDR_POWER_CONTROL, 8'h20);
		chk(psrw_pkg::ADDR_SCRATCH, 8'h5a);
		unlock();
		wt(psrw_pkg::ADDR_GLOBAL_CFG, 8'h00);
		$display("watchdog done");
	endtask
	task automatic t_pin;
		@(negedge clk) {pen, rpin} = 2'b11;
		wait_rst(1);
		@(negedge clk) rpin = 0;
		wait_rst(0);
		chk(psrw_pkg::ADDR_POWER_CONTROL, 8'h30);
		$display("pin done");
	endtask
	task automatic t_supply;
		@(negedge clk) sup = 1;
		wait_rst(1);
		@(negedge clk) sup = 0;
		wait_rst(0);
		chk(psrw_pkg::ADDR_POWER_CONTROL, 8'h10);
		chk(psrw_pkg::ADDR_SCRATCH, 8'h00);
		$display("supply done");
	endtask
	task automatic t_flag;
		wt(psrw_pkg::ADDR_WDOG_COUNTER, 8'hff);
		repeat (8) @(negedge clk);
		chk(psrw_pkg::ADDR_CLOCK_CFG, 8'h20);
		wt(psrw_pkg::ADDR_WDOG_COUNTER, 8'h00);
		chk(psrw_pkg::ADDR_CLOCK_CFG, 8'h00);
		$display("flag done");
	endtask
	task automatic t_soft;
		unlock();
		wt(psrw_pkg::ADDR_GLOBAL_CFG, 8'h10);
		wait_rst(1);
		wait_rst(0);
		chk(psrw_pkg::ADDR_POWER_CONTROL, 8'h10);
		chk(psrw_pkg::ADDR_GLOBAL_CFG, 8'hc0);
		unlock();
		wt(psrw_pkg::ADDR_GLOBAL_CFG, 8'h10);
		wait_rst(1);
		wait_rst(0);
		chk(psrw_pkg::ADDR_POWER_CONTROL, 8'h00);
		$display("soft done");
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#300000;
		miscompares++;
		print_verdict();
	end
	initial begin
		repeat (6) @(negedge clk);
		nrst = 1;
		wait_rst(0);
		chk(psrw_pkg::ADDR_POWER_CONTROL, psrw_pkg::RST_POWER_CONTROL);
		t_protect();
		t_sleep();
		t_wdog();
		t_pin();
		t_supply();
		t_flag();
		t_soft();
		print_verdict();
	end
endmodule // psrw_top_test
